//--- hw/sra_host_ctrl.sv
// Host controller driving an asynchronous 128K x 8 static RAM
module sra_host_ctrl #(
  parameter int unsigned RECOVERY_CYCLES = sra_pkg::RDR_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [sra_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sra_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [sra_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic retain_req,
  output logic retain_active,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [sra_pkg::ADDR_W-1:0] word_address,
  input wire logic [sra_pkg::DATA_W-1:0] shared_data_lines_i,
  output logic [sra_pkg::DATA_W-1:0] shared_data_lines_o,
  output logic shared_data_lines_oe
);

  localparam logic [sra_pkg::TMR_W-1:0] REC_LOAD =
    sra_pkg::TMR_W'(RECOVERY_CYCLES > 1 ? RECOVERY_CYCLES - 1 : 0);

  sra_pkg::sra_ctrl_s q, d;
  logic tmr_load;
  logic [sra_pkg::TMR_W-1:0] tmr_val;
  logic tmr_expired;

  sra_wait_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired)
  );

  // Release both selects together
  function automatic sra_pkg::sra_ctrl_s deselect(input sra_pkg::sra_ctrl_s s);
    sra_pkg::sra_ctrl_s r;
    r = s;
    r.sel_n = sra_pkg::SEL_N_RST;
    r.sel = sra_pkg::SEL_RST;
    return r;
  endfunction : deselect

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (q.state)
      sra_pkg::SRA_IDLE: begin
        if (retain_req) begin
          // Idle already has both selects released
          d.retain = 1'b1;
          tmr_load = 1'b1;
          tmr_val = sra_pkg::SDR_LOAD;
          d.state = sra_pkg::SRA_RET_SETUP;
        end else if (req_valid) begin
          // Address changes on the same edge as the selects activate
          d.addr = req_addr;
          d.sel_n = 1'b0;
          d.sel = 1'b1;
          if (req_write) begin
            d.wdata = req_wdata;
            d.state = sra_pkg::SRA_W_SET;
          end else begin
            d.oe_n = 1'b0;
            tmr_load = 1'b1;
            tmr_val = sra_pkg::ACC_LOAD;
            d.state = sra_pkg::SRA_R_ACC;
          end
        end
      end
      sra_pkg::SRA_W_SET: begin
        // Selects settled one cycle before strobe falls
        d.we_n = 1'b0;
        d.dq_oe = 1'b1;
        tmr_load = 1'b1;
        tmr_val = sra_pkg::WP_LOAD;
        d.state = sra_pkg::SRA_W_PULSE;
      end
      sra_pkg::SRA_W_PULSE: begin
        if (tmr_expired) begin
          d.we_n = 1'b1;
          d.state = sra_pkg::SRA_W_HOLD;
        end
      end
      sra_pkg::SRA_W_HOLD: begin
        // Data held one cycle past strobe rise
        d = deselect(d);
        d.dq_oe = 1'b0;
        d.rsp_valid = 1'b1;
        d.state = sra_pkg::SRA_IDLE;
      end
      sra_pkg::SRA_R_ACC: begin
        if (tmr_expired) begin
          d.rdata = shared_data_lines_i;
          d.rsp_valid = 1'b1;
          d.oe_n = 1'b1;
          d = deselect(d);
          d.state = sra_pkg::SRA_R_END;
        end
      end
      sra_pkg::SRA_R_END: begin
        // Turnaround so the device output floats before any drive
        d.state = sra_pkg::SRA_IDLE;
      end
      sra_pkg::SRA_RET_SETUP: begin
        if (tmr_expired) begin
          d.state = sra_pkg::SRA_RETAIN;
        end
      end
      sra_pkg::SRA_RETAIN: begin
        if (!retain_req) begin
          tmr_load = 1'b1;
          tmr_val = REC_LOAD;
          d.state = sra_pkg::SRA_RECOVER;
        end
      end
      sra_pkg::SRA_RECOVER: begin
        if (tmr_expired) begin
          d.retain = 1'b0;
          d.state = sra_pkg::SRA_IDLE;
        end
      end
      default: begin
        d = deselect(d);
        d.state = sra_pkg::SRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.state <= sra_pkg::SRA_IDLE;
      q.sel_n <= sra_pkg::SEL_N_RST;
      q.sel <= sra_pkg::SEL_RST;
      q.we_n <= sra_pkg::WE_N_RST;
      q.oe_n <= sra_pkg::OE_N_RST;
    end else begin
      q <= d;
    end
  end

  assign req_ready = (q.state == sra_pkg::SRA_IDLE) && !retain_req;
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rdata;
  assign retain_active = q.retain;
  assign select_low_active_n = q.sel_n;
  assign select_high_active = q.sel;
  assign write_strobe_n = q.we_n;
  assign output_gate_n = q.oe_n;
  assign word_address = q.addr;
  assign shared_data_lines_o = q.wdata;
  assign shared_data_lines_oe = q.dq_oe;

  logic selected;
  assign selected = !select_low_active_n && select_high_active;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_DESELECT_NO_DRIVE: assert property (
    !selected |-> !shared_data_lines_oe && write_strobe_n && output_gate_n)
    else $error("Pins active while deselected");

  AST_NO_CONTENTION: assert property (
    !output_gate_n |-> !shared_data_lines_oe)
    else $error("Host drives lines while device output gated on");

  AST_READ_STROBE_HIGH: assert property (
    !output_gate_n |-> write_strobe_n && selected)
    else $error("Write strobe low during read");

  AST_WRITE_OVERLAP: assert property (
    !write_strobe_n |-> selected && shared_data_lines_oe)
    else $error("Write strobe low outside selection");

  AST_SELECT_BEFORE_STROBE: assert property (
    $fell(write_strobe_n) |-> $past(selected) && $past(output_gate_n))
    else $error("Selects not settled before write strobe fall");

  AST_WRITE_PULSE: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n ##1 !write_strobe_n ##1 write_strobe_n)
    else $error("Write pulse not two cycles");

  AST_DATA_AT_WRITE_END: assert property (
    $rose(write_strobe_n) |-> shared_data_lines_oe && selected
      ##1 !shared_data_lines_oe && !selected && rsp_valid)
    else $error("Data not held past write end");

  AST_READ_TIMING: assert property (
    $fell(output_gate_n) |-> !output_gate_n
      ##1 (!output_gate_n && $stable(word_address)) [*2]
      ##1 (rsp_valid && output_gate_n && !selected))
    else $error("Read access not three cycles");

  AST_ADDR_WITH_SELECT: assert property (
    selected && $past(selected) |-> $stable(word_address))
    else $error("Address moved during selection");

  AST_RETAIN_DESELECTED: assert property (
    retain_active |-> !selected && !req_ready)
    else $error("Selected during retention");

  AST_RETAIN_ENTRY: assert property (
    $rose(retain_active) |-> !$past(selected) && $past(retain_req))
    else $error("Retention entered while selected");

endmodule : sra_host_ctrl

//--- hw/sra_pkg.sv
// Constants and types for the static RAM host controller
// Functional notes
// - Host keeps selects steady during address reads
// - Host holds strobe high throughout reads
// - Host address valid by select activation
// - Host never drives lines while device reads
// - Host deselects device for low-supply retention
// - Deselect no later than supply reduction starts
package sra_pkg;

  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TMR_W = 20;

  localparam int unsigned CLK_NS = 8;
  // Read access time, write pulse width, retention set-up and recovery
  localparam int unsigned T_ACC_NS = 20;
  localparam int unsigned T_WP_NS = 12;
  localparam int unsigned T_SDR_NS = 0;
  localparam int unsigned T_RDR_MS = 5;

  localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SDR_CYC = (T_SDR_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                                    (T_SDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RDR_CYC = (T_RDR_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  localparam logic [TMR_W-1:0] ACC_LOAD = TMR_W'(ACC_CYC - 1);
  localparam logic [TMR_W-1:0] WP_LOAD = TMR_W'(WP_CYC - 1);
  localparam logic [TMR_W-1:0] SDR_LOAD = TMR_W'(SDR_CYC - 1);

  // Pin levels while idle
  localparam logic SEL_N_RST = 1'b1;
  localparam logic SEL_RST = 1'b0;
  localparam logic WE_N_RST = 1'b1;
  localparam logic OE_N_RST = 1'b1;

  typedef enum logic [3:0] {
    SRA_IDLE,
    SRA_W_SET,
    SRA_W_PULSE,
    SRA_W_HOLD,
    SRA_R_ACC,
    SRA_R_END,
    SRA_RET_SETUP,
    SRA_RETAIN,
    SRA_RECOVER
  } sra_state_e;

  typedef struct packed {
    sra_state_e state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic sel_n;
    logic sel;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic rsp_valid;
    logic retain;
  } sra_ctrl_s;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } sra_tmr_s;

endpackage : sra_pkg

//--- hw/sra_wait_timer.sv
// Down-counting wait timer for the static RAM host controller
module sra_wait_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [sra_pkg::TMR_W-1:0] load_val,
  output logic expired
);

  sra_pkg::sra_tmr_s q, d;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = (q.cnt == '0);

endmodule : sra_wait_timer

//--- bench/sra_ram_model.sv
// Behavioural model of the asynchronous static RAM on the far side
module sra_ram_model (
  input wire logic sel_n,
  input wire logic sel,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [sra_pkg::ADDR_W-1:0] addr,
  input wire logic [sra_pkg::DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [sra_pkg::DATA_W-1:0] line_d,
  output logic clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [sra_pkg::DATA_W-1:0] mem [0:(1<<sra_pkg::ADDR_W)-1];
  logic [sra_pkg::DATA_W-1:0] held;
  logic act;
  logic wr;
  logic drv;
  assign act = !sel_n && sel;
  assign wr = act && !we_n;
  assign drv = act && we_n && !oe_n;
  assign clash = drv && host_oe;
  // Released lines show the inverse of the last driven byte
  always @* begin
    if (host_oe) held = host_d;
    else if (drv) held = mem[addr];
  end
  assign line_d = host_oe ? host_d : (drv ? mem[addr] : ~held);
  always @(negedge wr) mem[addr] = line_d;
endmodule : sra_ram_model

//--- bench/tb.sv
// Self-checking bench for the static RAM host controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned REC = 8;
  typedef struct {logic w; logic [16:0] a; logic [7:0] d;} sra_row_s;
  logic clk, arst_n, req_valid, req_write, retain_req, req_ready, rsp_valid, retain_active;
  logic sel_n, sel, we_n, oe_n, dq_oe, clash, psel_n;
  logic [16:0] req_addr, word_address, pa;
  logic [7:0] req_wdata, rsp_rdata, dq_o, dq_w;
  int fail_count = 0;
  int checks_done = 0;
  int lat;
  sra_row_s rows [8] = '{'{1'h1, 17'h00000, 8'ha5}, '{1'h1, 17'h1ffff, 8'h5a},
    '{1'h0, 17'h00000, 8'ha5}, '{1'h0, 17'h1ffff, 8'h5a}, '{1'h1, 17'h00000, 8'h3c},
    '{1'h1, 17'h10000, 8'hff}, '{1'h0, 17'h00000, 8'h3c}, '{1'h0, 17'h10000, 8'hff}};
  sra_host_ctrl #(.RECOVERY_CYCLES(REC)) dut_u (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .retain_req(retain_req), .retain_active(retain_active), .select_low_active_n(sel_n),
    .select_high_active(sel), .write_strobe_n(we_n), .output_gate_n(oe_n),
    .word_address(word_address), .shared_data_lines_i(dq_w), .shared_data_lines_o(dq_o),
    .shared_data_lines_oe(dq_oe));
  sra_ram_model ram_u (.sel_n(sel_n), .sel(sel), .we_n(we_n), .oe_n(oe_n),
    .addr(word_address), .host_d(dq_o), .host_oe(dq_oe), .line_d(dq_w), .clash(clash));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic await(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (s !== v) begin
      $display("MISMATCH wait expected %h seen %h", v, s);
      fail_count++;
      conclude();
    end
  endtask : await
  task automatic do_op(input logic w, input logic [16:0] a, input logic [7:0] d, output int n);
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    await(req_ready, 1'h1, n);
    @(posedge clk);
    #1;
    req_valid = 1'h0;
    await(rsp_valid, 1'h1, n);
  endtask : do_op
  task automatic idle_pins;
    chk("sel_n", 17'(sra_pkg::SEL_N_RST), sel_n);
    chk("sel", 17'(sra_pkg::SEL_RST), sel);
    chk("we_n", 17'(sra_pkg::WE_N_RST), we_n);
    chk("oe_n", 17'(sra_pkg::OE_N_RST), oe_n);
    chk("dq_oe", 17'h0, dq_oe);
  endtask : idle_pins
  always @(posedge clk) begin
    if (arst_n === 1'h1) begin
      chk("contention", 17'h0, clash);
      chk("gate_strobe", 17'h1, we_n | oe_n);
      if (!sel_n && !psel_n) chk("addr_hold", pa, word_address);
      if (retain_active) chk("retain_desel", 17'h1, sel_n & !sel);
      if (retain_active) chk("retain_rsp", 17'h0, rsp_valid);
    end
    pa <= word_address;
    psel_n <= sel_n;
  end
  initial begin
    arst_n = 1'h0;
    {req_valid, req_write, retain_req, req_addr, req_wdata} = '0;
    repeat (12) @(posedge clk);
    #1;
    idle_pins();
    arst_n = 1'h1;
    foreach (rows[i]) begin
      do_op(rows[i].w, rows[i].a, rows[i].d, lat);
      chk("latency", rows[i].w ? 17'h4 : 17'h3, 17'(lat));
      if (!rows[i].w) chk("rdata", 17'(rows[i].d), 17'(rsp_rdata));
    end
    retain_req = 1'h1;
    await(retain_active, 1'h1, lat);
    chk("ready_retain", 17'h0, req_ready);
    @(posedge clk);
    #1;
    retain_req = 1'h0;
    do_op(1'h0, 17'h00000, 8'h00, lat);
    chk("retained", 17'h3c, 17'(rsp_rdata));
    chk("retain_end", 17'h0, retain_active);
    req_write = 1'h1;
    req_addr = 17'h00001;
    req_valid = 1'h1;
    await(req_ready, 1'h1, lat);
    @(posedge clk);
    #1;
    req_valid = 1'h0;
    @(posedge clk);
    #1;
    arst_n = 1'h0;
    #1;
    idle_pins();
    @(posedge clk);
    #1;
    arst_n = 1'h1;
    do_op(1'h0, 17'h10000, 8'h00, lat);
    chk("after_reset", 17'hff, 17'(rsp_rdata));
    conclude();
  end
endmodule : tb
